/* shared/pllsy_pkg.sv */
// Constants, register map and mode encodings of the tuning synthesizer control block.
// Assumes a single 40 MHz clock and a nibble-wide internal register file port.
`default_nettype none
package pllsy_pkg;
	localparam logic [6:0] ADDR_REF_SELECT = 7'h11;
	localparam logic [6:0] ADDR_MODE_SELECT = 7'h12;
	localparam logic [3:0] REF_DISABLE_CODE = 4'hF;
	localparam logic [3:0] REF_RESET = 4'hF;
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [3:0] MODE_PINS_OFF = 4'h0;
	localparam int SWALLOW_LSB_BIT = 3;
	localparam logic [1:0] MODE_DIRECT = 2'h1;
	localparam logic [1:0] MODE_SWALLOW_LOW = 2'h2;
	localparam logic [1:0] MODE_SWALLOW_HIGH = 2'h3;
	localparam int DATA_WIDTH = 16;
	localparam int DIV_WIDTH = 17;
	localparam int REF_CNT_WIDTH = 24;
	localparam int CLK_HZ_DEFAULT = 40_000_000;

	typedef enum {PLLSY_PINS_OFF, PLLSY_DIRECT, PLLSY_SWALLOW_LOW, PLLSY_SWALLOW_HIGH} pllsy_mode_t;

	// Reference frequency in Hz per select code; zero marks a prohibited or disabling code.
	function automatic int ref_hz(input logic [3:0] code);
		case (code)
			4'h0: ref_hz = 1250;
			4'h1: ref_hz = 2500;
			4'h2: ref_hz = 5000;
			4'h3: ref_hz = 10000;
			4'h4: ref_hz = 6250;
			4'h5: ref_hz = 12500;
			4'h6: ref_hz = 25000;
			4'h7: ref_hz = 50000;
			4'h8: ref_hz = 3000;
			4'h9: ref_hz = 9000;
			4'hA: ref_hz = 18000;
			4'hC: ref_hz = 1000;
			4'hD: ref_hz = 20000;
			default: ref_hz = 0;
		endcase
	endfunction : ref_hz
endpackage : pllsy_pkg
`default_nettype wire

/* hdl/pllsy_divider.sv */
// Programmable divider: counts input edge ticks and emits one pulse per N ticks.
// Assumes ticks are single-cycle pulses already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module pllsy_divider
	import pllsy_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic tick,
	input wire logic [pllsy_pkg::DIV_WIDTH-1:0] ratio,
	output logic fn_pulse
);
	logic [DIV_WIDTH-1:0] count;
	logic [DIV_WIDTH-1:0] active_ratio;
	logic [DIV_WIDTH-1:0] next_count;
	logic [DIV_WIDTH-1:0] next_active_ratio;
	logic next_fn_pulse;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_count = count;
		next_active_ratio = active_ratio;
		next_fn_pulse = 1'b0;
		if (!run)
		begin
			next_count = '0;
			next_active_ratio = ratio;
		end
		else if (tick)
		begin
			// While running, the new ratio is taken only at wrap, so one period never mixes two values.
			if (count + 17'h00001 >= active_ratio)
			begin
				next_count = '0;
				next_active_ratio = ratio;
				next_fn_pulse = 1'b1;
			end
			else
			begin
				next_count = count + 17'h00001;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			count <= '0;
			active_ratio <= '0;
			fn_pulse <= 1'b0;
		end
		else
		begin
			count <= next_count;
			active_ratio <= next_active_ratio;
			fn_pulse <= next_fn_pulse;
		end
	end
endmodule : pllsy_divider
`default_nettype wire

/* hdl/pllsy_top.sv */
// Synthesizer control: disable logic, register file, input select, reference, comparator, pump.
// Assumes pins are asynchronous and reset strobes come from logic on clk.
`timescale 1ns/1ps
`default_nettype none
module pllsy_top
	import pllsy_pkg::*;
#(
	parameter int CLK_HZ = pllsy_pkg::CLK_HZ_DEFAULT
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic chip_enable,
	input wire logic watchdog_stack_reset,
	input wire logic clock_stop,
	input wire logic rf_write,
	input wire logic [6:0] rf_addr,
	input wire logic [3:0] rf_wdata,
	output logic [3:0] rf_rdata,
	input wire logic peripheral_write_instr,
	input wire logic [pllsy_pkg::DATA_WIDTH-1:0] write_data,
	input wire logic low_band_osc_input,
	input wire logic high_band_osc_input,
	output logic low_band_pulldown,
	output logic high_band_pulldown,
	output logic error_output_1_out,
	output logic error_output_1_oe_n,
	output logic error_output_0_out,
	output logic error_output_0_oe_n,
	output logic synth_disabled
);
	logic [1:0] ce_sync;
	logic [1:0] lo_sync;
	logic [1:0] hi_sync;
	logic lo_prev;
	logic hi_prev;
	logic [3:0] pll_reference_select;
	logic [3:0] mode_select;
	logic [DATA_WIDTH-1:0] division_data_register;
	logic swallow_lsb_latched;
	logic [REF_CNT_WIDTH-1:0] ref_count;
	logic fr_pulse;
	logic up_req;
	logic dn_req;
	logic fn_pulse;
	logic [3:0] next_ref;
	logic [3:0] next_mode;
	logic [DATA_WIDTH-1:0] next_data;
	logic next_lsb;
	logic [3:0] next_rdata;
	logic [REF_CNT_WIDTH-1:0] next_ref_count;
	logic [REF_CNT_WIDTH-1:0] ref_period;
	logic next_fr_pulse;
	logic next_up;
	logic next_dn;
	logic disabled;
	logic pins_off;
	logic sel_tick;
	logic [DIV_WIDTH-1:0] ratio;
	pllsy_mode_t mode;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; only the second stage is read by logic.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ce_sync <= 2'h0;
			lo_sync <= 2'h0;
			hi_sync <= 2'h0;
			lo_prev <= 1'b0;
			hi_prev <= 1'b0;
		end
		else
		begin
			ce_sync <= {ce_sync[0], chip_enable};
			lo_sync <= {lo_sync[0], low_band_osc_input};
			hi_sync <= {hi_sync[0], high_band_osc_input};
			lo_prev <= lo_sync[1];
			hi_prev <= hi_sync[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Disable and mode decode.
	always_comb
	begin
		disabled = !ce_sync[1] || (pll_reference_select == REF_DISABLE_CODE);
		pins_off = (mode_select == MODE_PINS_OFF);
		case (mode_select[1:0])
			MODE_DIRECT: mode = PLLSY_DIRECT;
			MODE_SWALLOW_LOW: mode = PLLSY_SWALLOW_LOW;
			MODE_SWALLOW_HIGH: mode = PLLSY_SWALLOW_HIGH;
			default: mode = PLLSY_PINS_OFF;
		endcase
		case (mode)
			PLLSY_DIRECT: sel_tick = lo_sync[1] && !lo_prev;
			PLLSY_SWALLOW_LOW: sel_tick = lo_sync[1] && !lo_prev;
			// The dual-modulus prescaler sits ahead of this logic; its output enters here.
			PLLSY_SWALLOW_HIGH: sel_tick = hi_sync[1] && !hi_prev;
			default: sel_tick = 1'b0;
		endcase
		if (mode == PLLSY_DIRECT)
			ratio = {1'b0, division_data_register};
		else
			ratio = {division_data_register, swallow_lsb_latched};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file.
	always_comb
	begin
		next_ref = pll_reference_select;
		next_mode = mode_select;
		next_data = division_data_register;
		next_lsb = swallow_lsb_latched;
		if (rf_write && rf_addr == ADDR_REF_SELECT)
			next_ref = rf_wdata;
		if (rf_write && rf_addr == ADDR_MODE_SELECT)
			next_mode = rf_wdata;
		// The flag must already stand in the mode register; both halves load together.
		if (peripheral_write_instr)
		begin
			next_data = write_data;
			next_lsb = mode_select[SWALLOW_LSB_BIT];
		end
		// Chip-enable low reloads only the reference code; the mode register is kept.
		if (watchdog_stack_reset || clock_stop || !ce_sync[1])
			next_ref = REF_RESET;
		case (rf_addr)
			ADDR_REF_SELECT: next_rdata = pll_reference_select;
			ADDR_MODE_SELECT: next_rdata = mode_select;
			default: next_rdata = 4'h0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pll_reference_select <= REF_RESET;
			mode_select <= MODE_RESET;
			division_data_register <= '0;
			swallow_lsb_latched <= 1'b0;
			rf_rdata <= 4'h0;
		end
		else
		begin
			pll_reference_select <= next_ref;
			mode_select <= next_mode;
			division_data_register <= next_data;
			swallow_lsb_latched <= next_lsb;
			rf_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reference generator, comparator and charge pump. Halt has no input here: it stops
	// nothing, so configured operation simply carries on while chip enable is high.
	always_comb
	begin
		ref_period = REF_CNT_WIDTH'(ref_hz(pll_reference_select) == 0 ? 0
			: CLK_HZ / ref_hz(pll_reference_select));
		next_ref_count = ref_count;
		next_fr_pulse = 1'b0;
		next_up = up_req;
		next_dn = dn_req;
		if (disabled || ref_period == '0)
			next_ref_count = '0;
		else if (ref_count + 24'h000001 >= ref_period)
		begin
			next_ref_count = '0;
			next_fr_pulse = 1'b1;
		end
		else
			next_ref_count = ref_count + 24'h000001;
		if (disabled)
		begin
			next_up = 1'b0;
			next_dn = 1'b0;
		end
		else if (fr_pulse && fn_pulse)
		begin
			next_up = 1'b0;
			next_dn = 1'b0;
		end
		else if (fr_pulse)
		begin
			next_up = !dn_req;
			next_dn = 1'b0;
		end
		else if (fn_pulse)
		begin
			next_dn = !up_req;
			next_up = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ref_count <= '0;
			fr_pulse <= 1'b0;
			up_req <= 1'b0;
			dn_req <= 1'b0;
			low_band_pulldown <= 1'b1;
			high_band_pulldown <= 1'b1;
			error_output_1_out <= 1'b0;
			error_output_0_out <= 1'b0;
			error_output_1_oe_n <= 1'b1;
			error_output_0_oe_n <= 1'b1;
			synth_disabled <= 1'b1;
		end
		else
		begin
			ref_count <= next_ref_count;
			fr_pulse <= next_fr_pulse;
			up_req <= next_up;
			dn_req <= next_dn;
			// An unselected pin is pulled down as well, except the low pin under mode codes 4, 8 and C, which is left to float.
			low_band_pulldown <= disabled || pins_off || mode == PLLSY_SWALLOW_HIGH;
			high_band_pulldown <= disabled || pins_off || mode != PLLSY_SWALLOW_HIGH;
			error_output_1_out <= dn_req;
			error_output_0_out <= dn_req;
			error_output_1_oe_n <= disabled || !(up_req || dn_req);
			error_output_0_oe_n <= disabled || !(up_req || dn_req);
			synth_disabled <= disabled;
		end
	end

	pllsy_divider u_divider (
		.clk(clk),
		.nrst(nrst),
		.run(!disabled),
		.tick(sel_tick),
		.ratio(ratio),
		.fn_pulse(fn_pulse)
	);

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	ce_low_disable_a: assert property (!ce_sync[1] |=> synth_disabled) else $error("ce low not disabling");
	ref_code_disable_a: assert property (pll_reference_select == REF_DISABLE_CODE |=> synth_disabled)
		else $error("all-ones reference not disabling");
	disabled_float_a: assert property (synth_disabled |-> error_output_1_oe_n && error_output_0_oe_n
		&& low_band_pulldown && high_band_pulldown) else $error("disabled outputs wrong");
	pins_off_a: assert property (ce_sync[1] && pll_reference_select != REF_DISABLE_CODE && pins_off
		|=> low_band_pulldown && high_band_pulldown && !synth_disabled) else $error("pins-off wrong");
	mode_kept_a: assert property (!ce_sync[1] && !(rf_write && rf_addr == ADDR_MODE_SELECT)
		|=> $stable(mode_select)) else $error("mode lost in ce reset");
	reset_code_a: assert property (watchdog_stack_reset || clock_stop |=> pll_reference_select == REF_RESET)
		else $error("reference not reloaded");
	no_request_a: assert property (disabled |=> !up_req && !dn_req) else $error("request while disabled");
	swallow_join_a: assert property (peripheral_write_instr |=> swallow_lsb_latched
		== $past(mode_select[SWALLOW_LSB_BIT]) && division_data_register == $past(write_data))
		else $error("division value split");
	ref_stop_a: assert property (disabled [*3] |-> !fr_pulse) else $error("reference ran while disabled");

	direct_run_c: cover property (mode == PLLSY_DIRECT && !disabled ##1 fn_pulse);
	high_band_c: cover property (mode == PLLSY_SWALLOW_HIGH && fr_pulse);
	ce_return_c: cover property (!ce_sync[1] ##1 ce_sync[1]);
endmodule : pllsy_top
`default_nettype wire

/* bench/pllsy_osc_model.sv */
// Behavioural oscillator standing at one band pin of the synthesizer.
// Assumes half_cyc counts 25.3 ns steps; zero stops the oscillator.
`timescale 1ns/1ps
`default_nettype none
module pllsy_osc_model (
	input wire logic [7:0] half_cyc,
	input wire logic hold_low,
	output logic pin
);
	logic osc = 1'b0;

	////////////////////////////////////////////////////////////////////
	// The step is off the clock period so edges drift against clk.
	always
	begin
		#(25.3 * ((half_cyc == 8'h00) ? 1 : half_cyc));
		osc = (half_cyc == 8'h00) ? 1'b0 : ~osc;
	end

	assign pin = osc & ~hold_low;
endmodule : pllsy_osc_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the synthesizer control block.
// Assumes one oscillator model at each band pin and a shortened reference period.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pllsy_pkg::*;
	typedef struct {logic [3:0] r; logic [3:0] m; logic [2:0] e;} pllsy_row_t;
	logic clk, nrst, ce, wsr, cstop, rfw, pwi;
	logic [6:0] addr;
	logic [3:0] wd, rd;
	logic [15:0] wdata;
	logic [7:0] hl, hh;
	logic osc_l, osc_h, pd_l, pd_h, e1, e1n, e0, e0n, dis;
	int error_cnt = 0;
	int samples_checked = 0;
	// Rows: reference code, mode, expected {disable, low pulldown, high pulldown}.
	pllsy_row_t rows [6] = '{'{4'hF, 4'h1, 3'b111}, '{4'h3, 4'h0, 3'b011},
		'{4'h3, 4'h1, 3'b001}, '{4'h3, 4'h2, 3'b001}, '{4'h3, 4'h3, 3'b010},
		'{4'hB, 4'h1, 3'b001}};

	pllsy_top #(.CLK_HZ(400000)) i_pllsy_top (.clk(clk), .nrst(nrst), .chip_enable(ce),
		.watchdog_stack_reset(wsr), .clock_stop(cstop), .rf_write(rfw), .rf_addr(addr),
		.rf_wdata(wd), .rf_rdata(rd), .peripheral_write_instr(pwi), .write_data(wdata),
		.low_band_osc_input(osc_l), .high_band_osc_input(osc_h), .low_band_pulldown(pd_l),
		.high_band_pulldown(pd_h), .error_output_1_out(e1), .error_output_1_oe_n(e1n),
		.error_output_0_out(e0), .error_output_0_oe_n(e0n), .synth_disabled(dis));
	pllsy_osc_model i_pllsy_osc_model_l (.half_cyc(hl), .hold_low(pd_l), .pin(osc_l));
	pllsy_osc_model i_pllsy_osc_model_h (.half_cyc(hh), .hold_low(pd_h), .pin(osc_h));

	////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [6:0] a, input logic [3:0] d);
		rfw = 1'b1;
		addr = a;
		wd = d;
		@(negedge clk);
		rfw = 1'b0;
		// One idle edge keeps a following write from raising the strobe in the same step.
		@(negedge clk);
	endtask : wr

	task automatic rdchk(input logic [6:0] a, input logic [3:0] exp);
		addr = a;
		@(negedge clk);
		chk("rf_rdata", 16'(exp), 16'(rd));
	endtask : rdchk

	// Disable status is registered behind a two-stage pin sync, so allow four edges.
	task automatic settle();
		repeat (4) @(negedge clk);
	endtask : settle

	task automatic division(input logic [3:0] mode, input logic [15:0] d);
		wr(ADDR_MODE_SELECT, mode);
		wdata = d;
		pwi = 1'b1;
		@(negedge clk);
		pwi = 1'b0;
	endtask : division

	// A reference period spans 40 clocks and a divider period fewer, so the 800-edge wait is generous.
	task automatic wait_err(input logic exp);
		int i;
		for (i = 0; i < 800; i++)
		begin
			@(negedge clk);
			if (e0n === 1'b0 && e0 === exp)
				break;
		end
		chk("error_output_0 drive", 16'h1, 16'(i < 800));
		chk("error_output_1", 16'({1'b0, exp}), 16'({e1n, e1}));
		if (i == 800)
			stop_test();
	endtask : wait_err

	////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		{nrst, wsr, cstop, rfw, pwi, addr, wd, wdata, hl, hh} = '0;
		ce = 1'b1;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		chk("reset outputs", 16'h1F, 16'({dis, pd_l, pd_h, e1n, e0n}));
		rdchk(ADDR_REF_SELECT, REF_RESET);
		rdchk(ADDR_MODE_SELECT, MODE_RESET);
		foreach (rows[k])
		begin
			wr(ADDR_REF_SELECT, rows[k].r);
			wr(ADDR_MODE_SELECT, rows[k].m);
			settle();
			chk("disable and pulldowns", 16'(rows[k].e), 16'({dis, pd_l, pd_h}));
			rdchk(ADDR_REF_SELECT, rows[k].r);
			rdchk(ADDR_MODE_SELECT, rows[k].m);
		end
		wr(7'h13, 4'h5);
		rdchk(7'h13, 4'h0);
		hl = 8'd5;
		wr(ADDR_REF_SELECT, 4'h3);
		wr(ADDR_MODE_SELECT, MODE_PINS_OFF);
		wait_err(1'b0);
		division({2'b00, MODE_DIRECT}, 16'h0002);
		wait_err(1'b1);
		hl = 8'd0;
		hh = 8'd0;
		division(4'hB, 16'h0000);
		wait_err(1'b0);
		hh = 8'd5;
		wait_err(1'b1);
		hh = 8'd0;
		division(4'hA, 16'h0000);
		wait_err(1'b0);
		hl = 8'd5;
		wait_err(1'b1);
		ce = 1'b0;
		settle();
		chk("chip enable low", 16'h1F, 16'({dis, pd_l, pd_h, e1n, e0n}));
		rdchk(ADDR_REF_SELECT, REF_DISABLE_CODE);
		rdchk(ADDR_MODE_SELECT, 4'hA);
		ce = 1'b1;
		settle();
		chk("disable after enable", 16'h1, 16'(dis));
		for (int s = 0; s < 2; s++)
		begin
			wr(ADDR_REF_SELECT, 4'h3);
			settle();
			chk("enabled", 16'h0, 16'(dis));
			wsr = (s == 0);
			cstop = (s == 1);
			@(negedge clk);
			wsr = 1'b0;
			cstop = 1'b0;
			settle();
			chk("reset source", 16'h1, 16'(dis));
			rdchk(ADDR_REF_SELECT, REF_DISABLE_CODE);
		end
		nrst = 1'b0;
		@(negedge clk);
		nrst = 1'b1;
		rdchk(ADDR_MODE_SELECT, MODE_RESET);
		stop_test();
	end
endmodule : tb
`default_nettype wire
